/* core/acfc_regs.sv */
// Clamp and feedback configuration registers with APB slave and output-limit logic
// Summary of operation
// - Two-bit loop gain, very slow to very fast
// - Back-EMF gain bits 1:0, reset two
// - Gain decode differs by actuator mode
// - Calibration writes gain; software may overwrite
// - Steady clamp at 0x24, reset 100
// - Steady clamp only after overdrive ends
// - Output limit is lower of clamps
// - Battery clamp A at 0x25, reset 128
// - Battery clamps ignored during calibration, diagnostics
// - Battery clamp B at 0x26 overrides clamp A
// - Bit 7 selects 125 or 45 Hz
// - Bit 6 selects resync timing method
// - Drive time bits 4:0, reset 16
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module acfc_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Engine status
   input wire logic resonant_mode_i,
   input wire logic overdrive_active_i,
   input wire logic [7:0] overdrive_limit_i,
   input wire logic battery_threshold_a_i,
   input wire logic battery_threshold_b_i,
   input wire logic calibrating_i,
   input wire logic diagnosing_i,
   input wire logic cal_gain_valid_i,
   input wire logic [1:0] cal_gain_i,
   // Configuration to engines
   output acfc_pkg::acfc_cfg_type cfg_o,
   output logic [11:0] backemf_gain_x100_o,
   output logic [7:0] lowest_resonance_hz_o,
   output logic resync_from_drive_time_o,
   output logic [7:0] output_limit_o
);
   acfc_pkg::acfc_cfg_type cfg;
   acfc_pkg::acfc_cfg_type next_cfg;
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic pready;
   logic next_pready;
   logic pslverr;
   logic next_pslverr;
   logic [11:0] gain_x100;
   logic [11:0] next_gain_x100;
   logic [7:0] freq_hz;
   logic [7:0] next_freq_hz;
   logic resync;
   logic next_resync;
   logic [7:0] limit;
   logic [7:0] next_limit;
   logic [7:0] bat_a_s1;
   logic [7:0] bat_a_s2;
   logic bat_b_s1;
   logic bat_b_s2;
   logic bat_a_s;
   logic bat_b_s;
   logic reserved_bit;
   logic next_reserved_bit;

   function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
      min8 = (a < b) ? a : b;
   endfunction : min8

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
         (a[9:2] >= acfc_pkg::OFS_FEEDBACK) && (a[9:2] <= acfc_pkg::OFS_STATUS);
   endfunction : mapped

   // Battery comparator levels arrive from the analog side
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         bat_a_s1 <= 8'h00;
         bat_a_s2 <= 8'h00;
         bat_b_s1 <= 1'b0;
         bat_b_s2 <= 1'b0;
      end
      else
      begin
         bat_a_s1 <= {7'h00, battery_threshold_a_i};
         bat_a_s2 <= bat_a_s1;
         bat_b_s1 <= battery_threshold_b_i;
         bat_b_s2 <= bat_b_s1;
      end
   end
   assign bat_a_s = bat_a_s2[0];
   assign bat_b_s = bat_b_s2;

   // Word addresses: the documented offsets are byte offsets of 8-bit registers
   always_comb
   begin
      logic [7:0] idx;
      logic acc;
      logic wr;
      idx = paddr_i[9:2];
      acc = psel_i && penable_i && !pready;
      // Write lands on the edge where the master samples pready high
      wr = psel_i && penable_i && pready && pwrite_i && mapped(paddr_i);
      next_cfg = cfg;
      next_reserved_bit = reserved_bit;
      next_pready = acc;
      next_pslverr = acc && !mapped(paddr_i);
      next_prdata = 32'h0000_0000;
      if (wr && idx == acfc_pkg::OFS_FEEDBACK)
      begin
         next_cfg.loop_gain = pwdata_i[acfc_pkg::POS_LOOP_GAIN +: 2];
         next_cfg.backemf_amp_gain = pwdata_i[1:0];
      end
      if (wr && idx == acfc_pkg::OFS_STEADY)
         next_cfg.steady_output_limit = pwdata_i[7:0];
      if (wr && idx == acfc_pkg::OFS_BAT_A)
         next_cfg.low_battery_overdrive_limit_a = pwdata_i[7:0];
      if (wr && idx == acfc_pkg::OFS_BAT_B)
         next_cfg.low_battery_overdrive_limit_b = pwdata_i[7:0];
      if (wr && idx == acfc_pkg::OFS_RESON)
      begin
         next_cfg.lowest_resonance_select = pwdata_i[acfc_pkg::POS_MIN_FREQ];
         next_cfg.resync_timing_method = pwdata_i[acfc_pkg::POS_RESYNC];
         next_reserved_bit = pwdata_i[acfc_pkg::POS_RESERVED];
         next_cfg.drive_time = pwdata_i[4:0];
      end
      // Calibration result beats a same-cycle software write: it is the newer fact
      if (cal_gain_valid_i)
         next_cfg.backemf_amp_gain = cal_gain_i;
      if (acc && !pwrite_i && mapped(paddr_i))
      begin
         unique case (idx)
            acfc_pkg::OFS_FEEDBACK:
               next_prdata[7:0] = {4'h0, cfg.loop_gain, cfg.backemf_amp_gain};
            acfc_pkg::OFS_STEADY: next_prdata[7:0] = cfg.steady_output_limit;
            acfc_pkg::OFS_BAT_A: next_prdata[7:0] = cfg.low_battery_overdrive_limit_a;
            acfc_pkg::OFS_BAT_B: next_prdata[7:0] = cfg.low_battery_overdrive_limit_b;
            acfc_pkg::OFS_RESON:
               next_prdata[7:0] = {cfg.lowest_resonance_select, cfg.resync_timing_method,
                  reserved_bit, cfg.drive_time};
            acfc_pkg::OFS_STATUS: next_prdata[7:0] = limit;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Derived engine settings
   always_comb
   begin
      logic [7:0] od;
      od = overdrive_limit_i;
      unique case ({resonant_mode_i, cfg.backemf_amp_gain})
         3'b100: next_gain_x100 = acfc_pkg::GAIN_RES_0;
         3'b101: next_gain_x100 = acfc_pkg::GAIN_RES_1;
         3'b110: next_gain_x100 = acfc_pkg::GAIN_RES_2;
         3'b111: next_gain_x100 = acfc_pkg::GAIN_RES_3;
         3'b000: next_gain_x100 = acfc_pkg::GAIN_ECC_0;
         3'b001: next_gain_x100 = acfc_pkg::GAIN_ECC_1;
         3'b010: next_gain_x100 = acfc_pkg::GAIN_ECC_2;
         3'b011: next_gain_x100 = acfc_pkg::GAIN_ECC_3;
      endcase
      next_freq_hz = cfg.lowest_resonance_select ? acfc_pkg::FREQ_LOW_HZ :
         acfc_pkg::FREQ_HIGH_HZ;
      next_resync = cfg.resync_timing_method;
      if (!(calibrating_i || diagnosing_i))
      begin
         if (bat_b_s)
            od = cfg.low_battery_overdrive_limit_b;
         else if (bat_a_s)
            od = cfg.low_battery_overdrive_limit_a;
      end
      // Steady clamp is held off while overdrive runs
      next_limit = overdrive_active_i ? od : min8(cfg.steady_output_limit, od);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         cfg <= '{steady_output_limit: acfc_pkg::RST_STEADY,
            low_battery_overdrive_limit_a: acfc_pkg::RST_BAT_A,
            low_battery_overdrive_limit_b: acfc_pkg::RST_BAT_B,
            backemf_amp_gain: acfc_pkg::RST_FEEDBACK[1:0],
            loop_gain: acfc_pkg::RST_FEEDBACK[3:2],
            lowest_resonance_select: acfc_pkg::RST_RESON[7],
            resync_timing_method: acfc_pkg::RST_RESON[6],
            drive_time: acfc_pkg::RST_RESON[4:0]};
         reserved_bit <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         gain_x100 <= acfc_pkg::GAIN_ECC_2;
         freq_hz <= acfc_pkg::FREQ_HIGH_HZ;
         resync <= 1'b0;
         limit <= 8'h00;
      end
      else
      begin
         cfg <= next_cfg;
         reserved_bit <= next_reserved_bit;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         gain_x100 <= next_gain_x100;
         freq_hz <= next_freq_hz;
         resync <= next_resync;
         limit <= next_limit;
      end
   end

   assign prdata_o = prdata;
   assign pready_o = pready;
   assign pslverr_o = pslverr;
   assign cfg_o = cfg;
   assign backemf_gain_x100_o = gain_x100;
   assign lowest_resonance_hz_o = freq_hz;
   assign resync_from_drive_time_o = resync;
   assign output_limit_o = limit;

   property p_steady_reset;
      @(posedge clk_i) $rose(rst_b_i) |-> cfg.steady_output_limit == 8'h64;
   endproperty
   a_steady_reset: assert property (p_steady_reset) else $error("steady reset wrong");

   property p_bat_reset;
      @(posedge clk_i) $rose(rst_b_i) |->
         cfg.low_battery_overdrive_limit_a == 8'h80 && cfg.low_battery_overdrive_limit_b == 8'h00;
   endproperty
   a_bat_reset: assert property (p_bat_reset) else $error("battery reset wrong");

   property p_gain_reset;
      @(posedge clk_i) $rose(rst_b_i) |-> cfg.backemf_amp_gain == 2'h2 && cfg.drive_time == 5'h10;
   endproperty
   a_gain_reset: assert property (p_gain_reset) else $error("gain reset wrong");

   property p_cal_write;
      @(posedge clk_i) disable iff (!rst_b_i)
         cal_gain_valid_i |=> cfg.backemf_amp_gain == $past(cal_gain_i);
   endproperty
   a_cal_write: assert property (p_cal_write) else $error("calibration gain lost");

   property p_limit_min;
      @(posedge clk_i) disable iff (!rst_b_i)
         !overdrive_active_i |=> limit <= cfg.steady_output_limit || $past(cfg) != cfg;
   endproperty
   a_limit_min: assert property (p_limit_min) else $error("steady clamp exceeded");

   property p_overdrive_free;
      @(posedge clk_i) disable iff (!rst_b_i)
         overdrive_active_i && !bat_a_s && !bat_b_s |=> limit == $past(overdrive_limit_i);
   endproperty
   a_overdrive_free: assert property (p_overdrive_free) else $error("clamp during overdrive");

   property p_cal_ignores_bat;
      @(posedge clk_i) disable iff (!rst_b_i)
         overdrive_active_i && calibrating_i |=> limit == $past(overdrive_limit_i);
   endproperty
   a_cal_ignores_bat: assert property (p_cal_ignores_bat) else $error("battery clamp in cal");

   property p_bat_b;
      @(posedge clk_i) disable iff (!rst_b_i)
         overdrive_active_i && bat_b_s && !calibrating_i && !diagnosing_i
         |=> limit == $past(cfg.low_battery_overdrive_limit_b);
   endproperty
   a_bat_b: assert property (p_bat_b) else $error("battery clamp b not used");

   property p_freq;
      @(posedge clk_i) disable iff (!rst_b_i)
         ##1 freq_hz == ($past(cfg.lowest_resonance_select) ? 8'h2D : 8'h7D);
   endproperty
   a_freq: assert property (p_freq) else $error("frequency select wrong");

   property p_bat_a;
      @(posedge clk_i) disable iff (!rst_b_i)
         overdrive_active_i && bat_a_s && !bat_b_s && !calibrating_i && !diagnosing_i
         |=> limit == $past(cfg.low_battery_overdrive_limit_a);
   endproperty
   a_bat_a: assert property (p_bat_a) else $error("battery clamp a not used");

   property p_resync;
      @(posedge clk_i) disable iff (!rst_b_i)
         ##1 resync == $past(cfg.resync_timing_method);
   endproperty
   a_resync: assert property (p_resync) else $error("resync method wrong");

   property p_sw_gain;
      @(posedge clk_i) disable iff (!rst_b_i)
         psel_i && penable_i && pready && pwrite_i && paddr_i == 12'h08C && !cal_gain_valid_i
         |=> cfg.backemf_amp_gain == 2'($past(pwdata_i));
   endproperty
   a_sw_gain: assert property (p_sw_gain) else $error("software gain write lost");

   c_write: cover property (@(posedge clk_i) psel_i && penable_i && pwrite_i && pready);
   c_bat_b: cover property (@(posedge clk_i) bat_b_s && overdrive_active_i);
   c_cal: cover property (@(posedge clk_i) cal_gain_valid_i);
   c_cal_race: cover property (@(posedge clk_i)
      cal_gain_valid_i && psel_i && penable_i && pready && pwrite_i);
   c_reset_release: cover property (@(posedge clk_i) $rose(rst_b_i));
endmodule : acfc_regs

/* core/acfc_pkg.sv */
// Package: offsets, reset values and types of the clamp and feedback config registers
package acfc_pkg;
   // Register offsets in the device's address space
   localparam logic [7:0] OFS_FEEDBACK = 8'h23;
   localparam logic [7:0] OFS_STEADY = 8'h24;
   localparam logic [7:0] OFS_BAT_A = 8'h25;
   localparam logic [7:0] OFS_BAT_B = 8'h26;
   localparam logic [7:0] OFS_RESON = 8'h27;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   // Reset values
   localparam logic [7:0] RST_FEEDBACK = 8'h06;
   localparam logic [7:0] RST_STEADY = 8'h64;
   localparam logic [7:0] RST_BAT_A = 8'h80;
   localparam logic [7:0] RST_BAT_B = 8'h00;
   localparam logic [7:0] RST_RESON = 8'h10;
   // Field positions
   localparam int POS_LOOP_GAIN = 2;
   localparam int POS_MIN_FREQ = 7;
   localparam int POS_RESYNC = 6;
   localparam int POS_RESERVED = 5;
   // Back-EMF gain in hundredths, resonant then eccentric
   localparam logic [11:0] GAIN_RES_0 = 12'h1F4;
   localparam logic [11:0] GAIN_RES_1 = 12'h3E8;
   localparam logic [11:0] GAIN_RES_2 = 12'h7D0;
   localparam logic [11:0] GAIN_RES_3 = 12'hBB8;
   localparam logic [11:0] GAIN_ECC_0 = 12'h022;
   localparam logic [11:0] GAIN_ECC_1 = 12'h069;
   localparam logic [11:0] GAIN_ECC_2 = 12'h0B6;
   localparam logic [11:0] GAIN_ECC_3 = 12'h190;
   // Lowest resonance in Hz
   localparam logic [7:0] FREQ_HIGH_HZ = 8'h7D;
   localparam logic [7:0] FREQ_LOW_HZ = 8'h2D;

   typedef enum logic [1:0] {
      LOOP_VERY_SLOW = 2'b00,
      LOOP_SLOW = 2'b01,
      LOOP_FAST = 2'b10,
      LOOP_VERY_FAST = 2'b11
   } acfc_loop_type;

   typedef struct packed {
      logic [7:0] steady_output_limit;
      logic [7:0] low_battery_overdrive_limit_a;
      logic [7:0] low_battery_overdrive_limit_b;
      logic [1:0] backemf_amp_gain;
      logic [1:0] loop_gain;
      logic lowest_resonance_select;
      logic resync_timing_method;
      logic [4:0] drive_time;
   } acfc_cfg_type;
endpackage : acfc_pkg

/* test/acfc_tb.sv */
// Self-checking testbench for the clamp and feedback configuration registers
`timescale 1ns/1ps
module testbench;
   logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, r;
   logic pready_o, pslverr_o, e;
   logic res_m, od_act, ta, tb, cal, diag, cv;
   logic [7:0] od, s, la, lb, hz, lim;
   logic [1:0] cg, lg;
   logic [4:0] dt;
   logic [11:0] gx;
   logic rsy;
   acfc_pkg::acfc_cfg_type cfg;
   int n_errors = 0;
   int check_count = 0;
   logic [11:0] g_tab [8] = '{12'h022, 12'h069, 12'h0B6, 12'h190,
                             12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8};
   logic [11:0] rst_a [5] = '{12'h08C, 12'h090, 12'h094, 12'h098, 12'h09C};
   logic [7:0] rst_v [5] = '{8'h06, 8'h64, 8'h80, 8'h00, 8'h10};

   acfc_regs i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .resonant_mode_i(res_m), .overdrive_active_i(od_act), .overdrive_limit_i(od),
      .battery_threshold_a_i(ta), .battery_threshold_b_i(tb), .calibrating_i(cal),
      .diagnosing_i(diag), .cal_gain_valid_i(cv), .cal_gain_i(cg), .cfg_o(cfg),
      .backemf_gain_x100_o(gx), .lowest_resonance_hz_o(hz),
      .resync_from_drive_time_o(rsy), .output_limit_o(lim));

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   // Request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20)
      begin
         n_errors++;
         stop_test();
      end
      // Idle edge so a following call never reassigns psel in this time step
      @(posedge clk_i);
   endtask : apb

   function automatic logic [7:0] exp_lim(logic [7:0] s_v, logic [7:0] od_v, logic a_v,
      logic b_v, logic ign, logic act, logic [7:0] la_v, logic [7:0] lb_v);
      logic [7:0] sel;
      sel = (!ign && b_v) ? lb_v : (!ign && a_v) ? la_v : od_v;
      return act ? sel : ((s_v < sel) ? s_v : sel);
   endfunction : exp_lim

   initial
   begin
      {rst_b_i, psel_i, penable_i, pwrite_i, res_m, od_act, ta, tb, cal, diag, cv} = '0;
      paddr_i = '0;
      pwdata_i = '0;
      od = 8'hFF;
      cg = '0;
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      void'($urandom(32'hDEC4114A));
      foreach (rst_a[i])
      begin
         apb(1'b0, rst_a[i], 32'h0);
         chk("reset value", {24'h0, rst_v[i]}, r);
      end
      chk("min freq reset", 32'h0000_007D, {24'h0, hz});
      chk("resync reset", 32'h0, {31'h0, rsy});
      apb(1'b1, 12'h0A4, 32'h0000_00FF);
      apb(1'b0, 12'h0A4, 32'h0);
      chk("unmapped read", 32'h1, {r[30:0], e});
      for (int k = 0; k < 8; k++)
      begin
         lg = 2'($urandom);
         res_m <= k[2];
         apb(1'b1, 12'h08C, {28'h0, lg, k[1:0]});
         repeat (3) @(posedge clk_i);
         chk("gain scaled", {20'h0, g_tab[k]}, {20'h0, gx});
         chk("loop gain", {30'h0, lg}, {30'h0, cfg.loop_gain});
      end
      cg <= 2'h1;
      cv <= 1'b1;
      @(posedge clk_i);
      cv <= 1'b0;
      apb(1'b0, 12'h08C, 32'h0);
      chk("cal gain", 32'h1, {30'h0, r[1:0]});
      apb(1'b1, 12'h08C, 32'h0000_0002);
      apb(1'b0, 12'h08C, 32'h0);
      chk("sw gain", 32'h2, {30'h0, r[1:0]});
      for (int k = 0; k < 4; k++)
      begin
         dt = 5'($urandom);
         apb(1'b1, 12'h09C, {24'h0, k[1:0], 1'b0, dt});
         repeat (2) @(posedge clk_i);
         chk("min freq", k[1] ? 32'h0000_002D : 32'h0000_007D, {24'h0, hz});
         chk("resync", {31'h0, k[0]}, {31'h0, rsy});
         chk("drive time", {27'h0, dt}, {27'h0, cfg.drive_time});
      end
      for (int k = 0; k < 40; k++)
      begin
         s = (k == 0) ? 8'h00 : 8'($urandom);
         la = 8'($urandom);
         lb = 8'($urandom);
         apb(1'b1, 12'h090, {24'h0, s});
         apb(1'b1, 12'h094, {24'h0, la});
         apb(1'b1, 12'h098, {24'h0, lb});
         od <= 8'($urandom);
         {od_act, ta, tb, cal, diag} <= 5'($urandom);
         repeat (5) @(posedge clk_i);
         chk("limit", {24'h0, exp_lim(s, od, ta, tb, cal | diag, od_act, la, lb)},
            {24'h0, lim});
         apb(1'b0, 12'h0A0, 32'h0);
         chk("status limit", {24'h0, exp_lim(s, od, ta, tb, cal | diag, od_act, la, lb)},
            r);
         apb(1'b0, 12'h094, 32'h0);
         chk("clamp a", {24'h0, la}, r);
      end
      // Mid-run reset must restore the documented steady and clamp B values
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      apb(1'b0, 12'h090, 32'h0);
      chk("steady after reset", 32'h0000_0064, r);
      apb(1'b0, 12'h098, 32'h0);
      chk("clamp b after reset", 32'h0000_0000, r);
      stop_test();
   end
endmodule : testbench
